/* hw/hrt_regs.svh */
/*
 * Register offsets, field positions, reset values and timing counts of the
 * handler result and trigger port.
 * Assumes a 40 MHz system clock and byte addresses on a 32-bit Avalon-MM bus.
 */
`ifndef HRT_REGS_SVH
`define HRT_REGS_SVH

// ============================================================
// Register byte offsets
`define HRT_CTRL_OFS        4'h0
`define HRT_STATUS_OFS      4'h4
`define HRT_RESULT_OFS      4'h8
`define HRT_COUNT_OFS       4'hc

// ============================================================
// Control fields
`define HRT_CTRL_OUTSIDE    0
`define HRT_CTRL_RISE       1
`define HRT_CTRL_SOFT_GO    2
`define HRT_CTRL_RESET      2'h3

// ============================================================
// Status fields
`define HRT_STAT_BUSY       0
`define HRT_STAT_PASS       1
`define HRT_STAT_VALID      2

// ============================================================
// Station fail vector: six stations per test category
`define HRT_STATIONS        6
`define HRT_CATEGORIES      5
`define HRT_FAIL_BITS       30

// ============================================================
// Timing
`define HRT_CLK_PERIOD_NS   25
`define HRT_MIN_PULSE_NS    1000
`define HRT_MIN_PULSE_CYC   ((`HRT_MIN_PULSE_NS + `HRT_CLK_PERIOD_NS - 1) / `HRT_CLK_PERIOD_NS)
`define HRT_MIN_GAP_NS      0

`endif

/* hw/hrt_pkg.sv */
/*
 * Types of the handler result and trigger port.
 * Assumes nothing of its surroundings.
 */
package hrt_pkg;

    // ============================================================
    // Sequence state, one-hot
    typedef enum logic [1:0] {
        HRT_IDLE = 2'b01,
        HRT_RUN  = 2'b10
    } hrt_state_e;

    // ============================================================
    // Test categories in station fail vector order
    typedef enum logic [2:0] {
        HRT_INDUCTANCE = 3'h0,
        HRT_RESISTANCE = 3'h1,
        HRT_SURGE      = 3'h2,
        HRT_WITHSTAND  = 3'h3,
        HRT_INSULATION = 3'h4
    } hrt_category_e;

    typedef logic [7:0] hrt_width_t;

endpackage

/* hw/hrt_handler_port.sv */
/*
 * Handler port of a winding tester: qualifies the active-low start trigger,
 * runs the testing indicator and drives active-low pass and station fail
 * flags, with an Avalon-MM register slave for control and status.
 * Assumes the measurement engine answers each start pulse with a one-cycle
 * done pulse carrying the 30-bit station fail vector, and that the handler
 * pin is already synchronous to MCLK.
 */
`include "hrt_regs.svh"

module hrt_handler_port #(
    parameter hrt_pkg::hrt_width_t PULSE_CYCLES = hrt_pkg::hrt_width_t'(`HRT_MIN_PULSE_CYC)
) (
    // Clock and reset
    input  wire logic        MCLK,
    input  wire logic        RESET,
    // Avalon-MM slave
    input  wire logic [3:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    // Handler trigger pin
    input  wire logic        START_N,
    // Handler result pins
    output logic             PASS_N,
    output logic             TESTING_N,
    output logic      [5:0]  INDUCTANCE_FAIL_N,
    output logic      [5:0]  RESISTANCE_FAIL_N,
    output logic      [5:0]  SURGE_FAIL_N,
    output logic      [5:0]  WITHSTAND_FAIL_N,
    output logic      [5:0]  INSULATION_FAIL_N,
    // Measurement engine
    output logic             SEQ_START,
    input  wire logic        SEQ_DONE,
    input  wire logic [29:0] STATION_FAIL
);

    // ============================================================
    // Declarations
    hrt_pkg::hrt_state_e state;
    logic                outside_trigger_mode;
    logic                edge_rise;
    logic                start_prev;
    hrt_pkg::hrt_width_t low_cnt;
    logic [29:0]         fail_n;
    logic                result_valid;
    logic [15:0]         trig_count;
    logic [15:0]         reject_count;
    logic                bus_req;
    logic                bus_take;
    logic                soft_go;
    logic                rise_seen;
    logic                rise_ok;
    logic                fall_ok;
    logic                outside_go;
    logic                go;
    logic                done;
    logic [31:0]         next_readdata;

    // Decode of a register offset, shared by read and write paths
    function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs);
        hit = (addr == ofs);
    endfunction

    // ============================================================
    // Bus handshake: one wait cycle, then the request is taken
    assign bus_req  = AVS_READ | AVS_WRITE;
    assign bus_take = bus_req & ~AVS_WAITREQUEST;

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            AVS_WAITREQUEST <= 1'b1;
        end else begin
            AVS_WAITREQUEST <= ~(bus_req & AVS_WAITREQUEST);
        end
    end

    always_comb begin
        next_readdata = 32'h0000_0000;
        if (hit(AVS_ADDRESS, `HRT_CTRL_OFS)) begin
            next_readdata[`HRT_CTRL_OUTSIDE] = outside_trigger_mode;
            next_readdata[`HRT_CTRL_RISE]    = edge_rise;
        end else if (hit(AVS_ADDRESS, `HRT_STATUS_OFS)) begin
            next_readdata[`HRT_STAT_BUSY]  = (state == hrt_pkg::HRT_RUN);
            next_readdata[`HRT_STAT_PASS]  = ~PASS_N;
            next_readdata[`HRT_STAT_VALID] = result_valid;
        end else if (hit(AVS_ADDRESS, `HRT_RESULT_OFS)) begin
            next_readdata[29:0] = ~fail_n;
        end else if (hit(AVS_ADDRESS, `HRT_COUNT_OFS)) begin
            next_readdata = {reject_count, trig_count};
        end
    end

    // Read data is loaded as waitrequest drops, so it stands at the taking edge
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            AVS_READDATA <= 32'h0000_0000;
        end else if (AVS_READ & AVS_WAITREQUEST) begin
            AVS_READDATA <= next_readdata;
        end
    end

    // ============================================================
    // Control register
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            {edge_rise, outside_trigger_mode} <= `HRT_CTRL_RESET;
        end else if (bus_take & AVS_WRITE & AVS_BYTEENABLE[0]
                     & hit(AVS_ADDRESS, `HRT_CTRL_OFS)) begin
            outside_trigger_mode <= AVS_WRITEDATA[`HRT_CTRL_OUTSIDE];
            edge_rise            <= AVS_WRITEDATA[`HRT_CTRL_RISE];
        end
    end

    // Software start works only while the outside trigger is off
    assign soft_go = bus_take & AVS_WRITE & AVS_BYTEENABLE[0]
                   & hit(AVS_ADDRESS, `HRT_CTRL_OFS)
                   & AVS_WRITEDATA[`HRT_CTRL_SOFT_GO] & ~outside_trigger_mode;

    // ============================================================
    // Trigger qualification: width of the low phase in cycles
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            start_prev <= 1'b1;
            low_cnt    <= 8'h00;
        end else begin
            start_prev <= START_N;
            if (START_N) begin
                low_cnt <= 8'h00;
            end else if (low_cnt != PULSE_CYCLES) begin
                low_cnt <= low_cnt + 8'h01;
            end
        end
    end

    assign rise_seen  = ~start_prev & START_N;
    assign rise_ok    = rise_seen & (low_cnt >= PULSE_CYCLES);
    assign fall_ok    = ~START_N & (low_cnt == PULSE_CYCLES - 8'h01);
    assign outside_go = outside_trigger_mode & (edge_rise ? rise_ok : fall_ok);
    assign go         = (state == hrt_pkg::HRT_IDLE) & (outside_go | soft_go);
    assign done       = (state == hrt_pkg::HRT_RUN) & SEQ_DONE;

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            reject_count <= 16'h0000;
        end else if (rise_seen & (low_cnt < PULSE_CYCLES)) begin
            reject_count <= reject_count + 16'h0001;
        end
    end

    // ============================================================
    // Sequence state and testing indicator
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            state     <= hrt_pkg::HRT_IDLE;
            TESTING_N <= 1'b1;
            SEQ_START <= 1'b0;
        end else begin
            SEQ_START <= go;
            unique case (state)
                hrt_pkg::HRT_IDLE: begin
                    if (go) begin
                        state     <= hrt_pkg::HRT_RUN;
                        TESTING_N <= 1'b0;
                    end
                end
                hrt_pkg::HRT_RUN: begin
                    if (SEQ_DONE) begin
                        state     <= hrt_pkg::HRT_IDLE;
                        TESTING_N <= 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            trig_count <= 16'h0000;
        end else if (go) begin
            trig_count <= trig_count + 16'h0001;
        end
    end

    // ============================================================
    // Results: loaded with the rise of the testing output, released on start
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            fail_n       <= '1;
            PASS_N       <= 1'b1;
            result_valid <= 1'b0;
        end else if (go) begin
            fail_n       <= '1;
            PASS_N       <= 1'b1;
            result_valid <= 1'b0;
        end else if (done) begin
            fail_n       <= ~STATION_FAIL;
            PASS_N       <= (STATION_FAIL != 30'h0000_0000);
            result_valid <= 1'b1;
        end
    end

    // Category slices of the station fail vector, six stations each
    for (genvar c = 0; c < `HRT_CATEGORIES; c++) begin : g_cat
        logic [5:0] slice;
        assign slice = fail_n[c*`HRT_STATIONS +: `HRT_STATIONS];
        if (c == hrt_pkg::HRT_INDUCTANCE) begin : g_l
            assign INDUCTANCE_FAIL_N = slice;
        end else if (c == hrt_pkg::HRT_RESISTANCE) begin : g_r
            assign RESISTANCE_FAIL_N = slice;
        end else if (c == hrt_pkg::HRT_SURGE) begin : g_s
            assign SURGE_FAIL_N = slice;
        end else if (c == hrt_pkg::HRT_WITHSTAND) begin : g_w
            assign WITHSTAND_FAIL_N = slice;
        end else begin : g_i
            assign INSULATION_FAIL_N = slice;
        end
    end

    // ============================================================
    // Assertions
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RESET);

    a_pass_from_fails: assert property (
        done |=> (PASS_N == ($past(STATION_FAIL) != 30'h0000_0000)))
        else $error("pass output does not match station results");

    a_testing_low_run: assert property (
        (go || (state == hrt_pkg::HRT_RUN && !SEQ_DONE)) |=> !TESTING_N)
        else $error("testing output not low while running");

    a_testing_ends: assert property (
        done |=> TESTING_N && state == hrt_pkg::HRT_IDLE)
        else $error("testing output not released at end");

    a_induct_fail: assert property (
        done |=> INDUCTANCE_FAIL_N == ~$past(STATION_FAIL[5:0]))
        else $error("inductance fail flags wrong");

    a_resist_fail: assert property (
        done |=> RESISTANCE_FAIL_N == ~$past(STATION_FAIL[11:6]))
        else $error("resistance fail flags wrong");

    a_surge_fail: assert property (
        done |=> SURGE_FAIL_N == ~$past(STATION_FAIL[17:12]))
        else $error("surge fail flags wrong");

    a_withstand_fail: assert property (
        done |=> WITHSTAND_FAIL_N == ~$past(STATION_FAIL[23:18]))
        else $error("withstand fail flags wrong");

    a_insul_fail: assert property (
        done |=> INSULATION_FAIL_N == ~$past(STATION_FAIL[29:24]))
        else $error("insulation fail flags wrong");

    a_rise_start: assert property (
        (state == hrt_pkg::HRT_IDLE && outside_trigger_mode && edge_rise && rise_ok)
        |=> SEQ_START && !TESTING_N)
        else $error("rising trigger did not start a sequence");

    a_fall_start: assert property (
        (state == hrt_pkg::HRT_IDLE && outside_trigger_mode && !edge_rise && fall_ok)
        |=> SEQ_START && !TESTING_N)
        else $error("falling trigger did not start a sequence");

    a_short_ignored: assert property (
        (outside_trigger_mode && rise_seen && low_cnt < PULSE_CYCLES && !soft_go)
        |=> !SEQ_START)
        else $error("short trigger pulse started a sequence");

    a_results_hold: assert property (
        (state == hrt_pkg::HRT_IDLE && !go) |=> $stable(fail_n) && $stable(PASS_N))
        else $error("results changed while idle");

    a_release_start: assert property (
        go |=> fail_n == 30'h3fff_ffff && PASS_N)
        else $error("results not released at start");

    a_retrigger: assert property (
        (done ##1 (outside_go || soft_go)) |=> SEQ_START)
        else $error("trigger right after completion was lost");

    c_rise_trigger: cover property (outside_trigger_mode && edge_rise && go);
    c_fall_trigger: cover property (outside_trigger_mode && !edge_rise && go);
    c_soft_trigger: cover property (soft_go && go);
    c_all_pass:     cover property (done && STATION_FAIL == 30'h0000_0000);
    c_retrigger:    cover property (done ##1 go);

endmodule

/* bench/hrt_handler_model.sv */
/*
 * Handler model: drives the active-low start pin with low pulses.
 * Assumes the bench calls pulse from its main sequence.
 */
module hrt_handler_model (
    // Clock
    input  wire logic MCLK,
    // Trigger pin
    output logic      START_N
);
    timeunit 1ns;
    timeprecision 1ps;

    initial START_N = 1'b1;

    // ============================================================
    // Low pulse of w cycles, then back to idle high
    task automatic pulse(input int w);
        @(posedge MCLK);
        START_N <= 1'b0;
        repeat (w) @(posedge MCLK);
        START_N <= 1'b1;
    endtask

    // Level held on the pin until the next call
    task automatic level(input logic b);
        START_N <= b;
    endtask
endmodule

/* bench/handler_result_trigger_port_tb_top.sv */
/*
 * Self-checking bench of the handler port, with an engine model.
 * Assumes the design header and the handler model are compiled first.
 */
`include "hrt_regs.svh"
module handler_result_trigger_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PC = 4;
    logic        MCLK, RESET, avs_rd, avs_wr, waitreq, pass_n, testing_n, seq_start;
    logic        seq_done = 1'b0;
    logic [3:0]  avs_addr, avs_be;
    logic [31:0] avs_wd, readdata, r;
    logic [5:0]  ind_n, res_n, srg_n, wst_n, ins_n;
    logic [29:0] station_fail = 30'h0, fv, v;
    wire         start_n;
    int          error_cnt, comparisons, acc, rej, cyc, dly, cnt;

    hrt_handler_port #(.PULSE_CYCLES(hrt_pkg::hrt_width_t'(PC))) u_dut (
        .MCLK(MCLK), .RESET(RESET), .AVS_ADDRESS(avs_addr), .AVS_READ(avs_rd),
        .AVS_WRITE(avs_wr), .AVS_WRITEDATA(avs_wd), .AVS_BYTEENABLE(avs_be),
        .AVS_READDATA(readdata), .AVS_WAITREQUEST(waitreq), .START_N(start_n),
        .PASS_N(pass_n), .TESTING_N(testing_n), .INDUCTANCE_FAIL_N(ind_n),
        .RESISTANCE_FAIL_N(res_n), .SURGE_FAIL_N(srg_n), .WITHSTAND_FAIL_N(wst_n),
        .INSULATION_FAIL_N(ins_n), .SEQ_START(seq_start), .SEQ_DONE(seq_done),
        .STATION_FAIL(station_fail));
    hrt_handler_model u_hdl (.MCLK(MCLK), .START_N(start_n));

    initial begin
        MCLK = 1'b0;
        forever #12.5 MCLK = ~MCLK;
    end

    // ============================================================
    // Engine: done after dly cycles; fail lines toggle when not valid
    always @(posedge MCLK) begin
        seq_done <= !RESET && cnt == 1;
        station_fail <= (!RESET && cnt == 1) ? fv : ~station_fail;
        if (RESET) begin
            cnt <= 0;
        end else if (seq_start) begin
            cnt <= dly;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end

    always @(posedge MCLK) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            finish_test();
        end
    end

    // ============================================================
    // Helpers
    function logic [30:0] outs();
        return {pass_n, ins_n, wst_n, srg_n, res_n, ind_n};
    endfunction

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        int n;
        @(posedge MCLK);
        avs_addr <= a;
        avs_wd <= wd;
        avs_rd <= !wr;
        avs_wr <= wr;
        n = 0;
        do begin
            @(posedge MCLK);
            n++;
        end while (waitreq !== 1'b0 && n < 100);
        if (n == 100) chk("waitrequest", 32'h0, {31'h0, waitreq});
        r = readdata;
        avs_rd <= 1'b0;
        avs_wr <= 1'b0;
    endtask

    task wait_t(input logic b);
        int n;
        n = 0;
        while (testing_n !== b && n < 300) begin
            @(posedge MCLK);
            n++;
        end
        if (n == 300) chk("testing wait", b, testing_n);
    endtask

    // Width 0 starts by software, else by a pin pulse of w cycles
    task run_seq(input logic [29:0] x, input int w, input int d, input int h);
        fv = x;
        dly = d;
        if (w == 0) bus(1'b1, `HRT_CTRL_OFS, 32'h4);
        else u_hdl.pulse(w);
        wait_t(1'b0);
        chk("released", 31'h7fffffff, outs());
        wait_t(1'b1);
        chk("results", {|x, ~x}, outs());
        repeat (h) @(posedge MCLK);
        chk("held", {|x, ~x}, outs());
    endtask

    task finish_test();
        $display("counts: %0d compared, %0d mismatched", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // ============================================================
    // Main sequence
    initial begin
        RESET = 1'b1;
        {avs_rd, avs_wr, avs_addr, avs_wd} = '0;
        avs_be = 4'hf;
        {error_cnt, comparisons, acc, rej, cyc, dly} = '0;
        fv = 30'h0;
        void'($urandom(82));
        repeat (16) @(posedge MCLK);
        RESET <= 1'b0;
        @(posedge MCLK);
        chk("reset outs", 31'h7fffffff, outs());
        chk("reset testing", 1'b1, testing_n);
        bus(1'b0, `HRT_CTRL_OFS, 32'h0);
        chk("ctrl", {30'h0, `HRT_CTRL_RESET}, r);
        bus(1'b0, 4'h2, 32'h0);
        chk("unmapped", 32'h0, r);
        $display("test reset done");
        for (int m = 0; m < 2; m++) begin
            bus(1'b1, `HRT_CTRL_OFS, {30'h0, m[0], 1'b1});
            for (int i = 0; i < 7; i++) begin
                v = (i == 0) ? 30'h0 : (i == 6) ? 30'($urandom)
                  : 30'($urandom_range(1, 63)) << (6 * (i - 1));
                run_seq(v, PC + $urandom_range(0, 3), $urandom_range(10, 20), i % 2 * 3);
                acc++;
            end
            u_hdl.pulse(PC - 1);
            repeat (6) @(posedge MCLK);
            chk("short pulse", 1'b1, testing_n);
            rej++;
            v = 30'($urandom) | 30'h1;
            if (m == 0) begin
                fv = v;
                dly = 10;
                u_hdl.pulse(PC + 30);
                chk("falling edge", {|v, ~v}, outs());
            end else begin
                run_seq(v, PC + 30, 10, 0);
            end
            acc++;
        end
        $display("test edges done");
        v = 30'($urandom);
        fv = v;
        dly = 40;
        u_hdl.pulse(PC);
        u_hdl.pulse(PC + 1);
        wait_t(1'b1);
        chk("busy results", {|v, ~v}, outs());
        repeat (6) @(posedge MCLK);
        chk("busy retrigger", 1'b1, testing_n);
        acc++;
        v = 30'($urandom);
        fv = v;
        dly = 12;
        u_hdl.pulse(PC);
        @(posedge MCLK);
        u_hdl.level(1'b0);
        while (seq_done !== 1'b1) @(posedge MCLK);
        u_hdl.level(1'b1);
        repeat (2) @(posedge MCLK);
        chk("retrigger at once", 1'b0, testing_n);
        wait_t(1'b1);
        chk("retrigger results", {|v, ~v}, outs());
        acc += 2;
        bus(1'b0, `HRT_COUNT_OFS, 32'h0);
        chk("count", {rej[15:0], acc[15:0]}, r);
        $display("test busy and count done");
        bus(1'b1, `HRT_CTRL_OFS, 32'h0);
        u_hdl.pulse(PC + 2);
        repeat (6) @(posedge MCLK);
        chk("pin in software mode", 1'b1, testing_n);
        v = 30'($urandom) | 30'h2;
        run_seq(v, 0, 12, 2);
        bus(1'b0, `HRT_STATUS_OFS, 32'h0);
        chk("status", 32'h4, r);
        bus(1'b0, `HRT_RESULT_OFS, 32'h0);
        chk("result", {2'h0, v}, r);
        $display("test software start done");
        finish_test();
    end
endmodule
